// ===== verilog/reader_seq_pkg.sv
// package of the reader command sequencer: command codes, register map,
// field positions, reset values and the structs that carry its signals.
// assumes one 20 MHz clock and a single AHB-Lite master.
package reader_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] CMD_IDLE = 8'h00;
  localparam logic [7:0] CMD_RECEIVE = 8'h16;
  localparam logic [7:0] CMD_TRANSMIT = 8'h1a;
  localparam logic [7:0] CMD_POWER_ON_INIT = 8'h3f;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets; offsets below PAGE0_END form page 0
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_MAIN_STATUS = 8'h04;
  localparam logic [7:0] OFS_REDUNDANCY_CONFIG = 8'h20;
  localparam logic [7:0] OFS_RX_START_DELAY = 8'h24;
  localparam logic [7:0] PAGE0_END = 8'h20;

  // main status register bits
  localparam int STS_CMD_DONE = 0;
  localparam int STS_TX_DONE = 1;
  localparam int STS_RX_DONE = 2;
  localparam int STS_TX_ARMED = 4;
  localparam int STS_TX_ACTIVE = 5;
  localparam int STS_RX_ACTIVE = 6;
  localparam int STS_ACCEPT_MORE = 7;

  // redundancy config register bits
  localparam int CFG_TX_CHECKSUM = 0;
  localparam int CFG_CRC8 = 1;
  localparam int CFG_LEGACY = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [7:0] RX_DELAY_RESET = 8'h03;

  // receiver preparation uses counts 3 down to 1
  localparam logic [7:0] RX_PREP_TOP = 8'h03;

  // cycles spent in the reset phase of the initialisation command
  localparam logic [2:0] RESET_PHASE_CYCLES = 3'h4;

  // checksum presets and reflected polynomials
  localparam logic [15:0] CRC16_PRESET = 16'hffff;
  localparam logic [15:0] CRC16_POLY = 16'h8408;
  localparam logic [7:0] CRC8_PRESET = 8'hff;
  localparam logic [7:0] CRC8_POLY = 8'h8c;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [3:0] {
    ST_RESET_PHASE, ST_INIT_LOAD, ST_IDLE, ST_TX_ARMED, ST_TX_START,
    ST_TX_DATA, ST_TX_CRC, ST_TX_EOF, ST_RX_WAIT, ST_RX_RUN
  } seq_state_t;

  typedef enum logic [1:0] {TXP_NONE, TXP_START, TXP_DATA, TXP_EOF} tx_phase_t;

  typedef struct packed {
    logic empty;
    logic [7:0] rdata;
  } fifo_in_t;

  typedef struct packed {
    logic push;
    logic [7:0] wdata;
  } fifo_wr_t;

  typedef struct packed {
    logic active;
    logic bit_val;
    tx_phase_t phase;
  } tx_out_t;

  typedef struct packed {
    logic byte_valid;
    logic [7:0] data;
    logic done;
  } rx_in_t;

  typedef struct packed {
    logic prep;
    logic enable;
  } rx_ctl_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rx_delay;
  } init_data_t;

  typedef struct packed {
    seq_state_t state;
    logic [7:0] cmd;
    logic [2:0] cfg;
    logic [7:0] rx_delay;
    logic [2:0] flags;
    logic [2:0] rst_cnt;
    logic [15:0] div_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic accept;
    logic crc_hi;
    logic [15:0] crc;
    logic [7:0] rx_cnt;
    logic [2:0] pin_sync;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic init_req;
    fifo_wr_t fifo_wr;
    tx_out_t tx;
    rx_ctl_t rx;
  } seq_t;

  localparam seq_t SEQ_RESET = '{
    state: ST_RESET_PHASE,
    cmd: CMD_POWER_ON_INIT,
    cfg: CFG_RESET,
    rx_delay: RX_DELAY_RESET,
    tx: '{active: 1'b0, bit_val: 1'b0, phase: TXP_NONE},
    default: '0
  };

endpackage : reader_seq_pkg

// ===== verilog/reader_command_sequencer.sv
// command sequencer of a contactless label reader: initialisation, idle,
// transmit (fifo to rf bit stream) and receive (decoded bytes to fifo).
// assumes the fifo, the eeprom loader and the rf decoder run on clock.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

module reader_command_sequencer #(
  parameter logic [15:0] BIT_DIV = 16'd128
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] haddr,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reset_powerdown_pin,
  output logic init_load_req,
  input wire logic init_load_done,
  input wire reader_seq_pkg::init_data_t init_data,
  input wire reader_seq_pkg::fifo_in_t fifo_in,
  output logic fifo_pop,
  output reader_seq_pkg::fifo_wr_t fifo_wr,
  output reader_seq_pkg::tx_out_t tx_out,
  input wire reader_seq_pkg::rx_in_t rx_in,
  output reader_seq_pkg::rx_ctl_t rx_ctl
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_page0(input logic [7:0] a);
    return a < reader_seq_pkg::PAGE0_END;
  endfunction : is_page0

  function automatic logic in_init(input reader_seq_pkg::seq_state_t s);
    return (s == reader_seq_pkg::ST_RESET_PHASE) || (s == reader_seq_pkg::ST_INIT_LOAD);
  endfunction : in_init

  // one byte through the reflected crc, 8 or 16 bits wide
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                           input logic eight);
    logic [15:0] r;
    logic [15:0] poly;
    logic fb;
    r = c;
    poly = eight ? {8'h00, reader_seq_pkg::CRC8_POLY} : reader_seq_pkg::CRC16_POLY;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ d[i];
      r = r >> 1;
      if (fb) begin
        r = r ^ poly;
      end
    end
    return r;
  endfunction : crc_byte

  function automatic logic [15:0] crc_preset(input logic eight);
    return eight ? {8'h00, reader_seq_pkg::CRC8_PRESET} : reader_seq_pkg::CRC16_PRESET;
  endfunction : crc_preset

  // end of data or checksum: eof in standard mode, done in legacy mode
  function automatic reader_seq_pkg::seq_t frame_tail(input reader_seq_pkg::seq_t s);
    reader_seq_pkg::seq_t r;
    r = s;
    if (s.cfg[reader_seq_pkg::CFG_LEGACY]) begin
      r.state = reader_seq_pkg::ST_IDLE;
      r.cmd = reader_seq_pkg::CMD_IDLE;
      r.flags[reader_seq_pkg::STS_TX_DONE] = 1'b1;
      r.flags[reader_seq_pkg::STS_CMD_DONE] = 1'b1;
    end else begin
      r.state = reader_seq_pkg::ST_TX_EOF;
    end
    return r;
  endfunction : frame_tail

  function automatic logic [31:0] reg_read(input reader_seq_pkg::seq_t s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      reader_seq_pkg::OFS_COMMAND: r[7:0] = s.cmd;
      reader_seq_pkg::OFS_MAIN_STATUS: begin
        r[2:0] = s.flags;
        r[reader_seq_pkg::STS_TX_ARMED] = s.state == reader_seq_pkg::ST_TX_ARMED;
        r[reader_seq_pkg::STS_TX_ACTIVE] = s.tx.active;
        r[reader_seq_pkg::STS_RX_ACTIVE] = s.rx.enable;
        r[reader_seq_pkg::STS_ACCEPT_MORE] = s.accept;
      end
      reader_seq_pkg::OFS_REDUNDANCY_CONFIG: r[2:0] = s.cfg;
      reader_seq_pkg::OFS_RX_START_DELAY: r[7:0] = s.rx_delay;
      default: r = '0;
    endcase
    return r;
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  reader_seq_pkg::seq_t q_ff;
  reader_seq_pkg::seq_t nxt_q;
  logic tick;
  logic pin_fall;
  logic addr_read;

  always_comb begin
    nxt_q = q_ff;
    fifo_pop = 1'b0;
    tick = 1'b0;
    nxt_q.fifo_wr.push = 1'b0;
    // pin passes two flops; the edge is seen between the second and third
    nxt_q.pin_sync = {q_ff.pin_sync[1:0], reset_powerdown_pin};
    pin_fall = q_ff.pin_sync[2] & ~q_ff.pin_sync[1];

    // bit clock enable
    if (q_ff.div_cnt >= BIT_DIV - 16'd1) begin
      nxt_q.div_cnt = '0;
      tick = 1'b1;
    end else begin
      nxt_q.div_cnt = q_ff.div_cnt + 16'd1;
    end

    // bus address phase: read data is prepared for the data phase
    addr_read = hsel & htrans[1] & hready & ~hwrite;
    nxt_q.dp_write = hsel & htrans[1] & hready & hwrite;
    nxt_q.dp_addr = haddr[7:0];
    if (addr_read) begin
      if (in_init(q_ff.state) && !is_page0(haddr[7:0])) begin
        nxt_q.rdata = '0;
      end else begin
        nxt_q.rdata = reg_read(q_ff, haddr[7:0]);
      end
    end

    // status flags clear by writing one; sets below win
    if (q_ff.dp_write && !in_init(q_ff.state) &&
        q_ff.dp_addr == reader_seq_pkg::OFS_MAIN_STATUS) begin
      nxt_q.flags = q_ff.flags & ~hwdata[2:0];
    end

    unique case (q_ff.state)
      reader_seq_pkg::ST_RESET_PHASE: begin
        // held here while the power-down pin is low
        if (!q_ff.pin_sync[1]) begin
          nxt_q.rst_cnt = '0;
        end else if (q_ff.rst_cnt == reader_seq_pkg::RESET_PHASE_CYCLES - 3'd1) begin
          nxt_q.state = reader_seq_pkg::ST_INIT_LOAD;
          nxt_q.init_req = 1'b1;
        end else begin
          nxt_q.rst_cnt = q_ff.rst_cnt + 3'd1;
        end
      end
      reader_seq_pkg::ST_INIT_LOAD: begin
        if (init_load_done) begin
          nxt_q.cfg = init_data.cfg[2:0];
          nxt_q.rx_delay = init_data.rx_delay;
          nxt_q.init_req = 1'b0;
          nxt_q.state = reader_seq_pkg::ST_IDLE;
          nxt_q.cmd = reader_seq_pkg::CMD_IDLE;
          nxt_q.flags[reader_seq_pkg::STS_CMD_DONE] = 1'b1;
        end
      end
      reader_seq_pkg::ST_IDLE: begin
        nxt_q.accept = 1'b0;
      end
      reader_seq_pkg::ST_TX_ARMED: begin
        if (!fifo_in.empty) begin
          fifo_pop = 1'b1;
          nxt_q.shreg = fifo_in.rdata;
          nxt_q.crc = crc_byte(crc_preset(q_ff.cfg[reader_seq_pkg::CFG_CRC8]),
                               fifo_in.rdata, q_ff.cfg[reader_seq_pkg::CFG_CRC8]);
          nxt_q.state = reader_seq_pkg::ST_TX_START;
          nxt_q.div_cnt = '0;
          nxt_q.accept = 1'b1;
        end
      end
      reader_seq_pkg::ST_TX_START: begin
        if (tick) begin
          nxt_q.state = reader_seq_pkg::ST_TX_DATA;
          nxt_q.bit_cnt = '0;
        end
      end
      reader_seq_pkg::ST_TX_DATA: begin
        if (tick) begin
          if (q_ff.bit_cnt == 3'd7) begin
            if (q_ff.accept) begin
              fifo_pop = 1'b1;
              nxt_q.shreg = fifo_in.rdata;
              nxt_q.crc = crc_byte(q_ff.crc, fifo_in.rdata,
                                   q_ff.cfg[reader_seq_pkg::CFG_CRC8]);
              nxt_q.bit_cnt = '0;
            end else if (q_ff.cfg[reader_seq_pkg::CFG_TX_CHECKSUM]) begin
              nxt_q.state = reader_seq_pkg::ST_TX_CRC;
              nxt_q.shreg = ~q_ff.crc[7:0];
              nxt_q.crc_hi = ~q_ff.cfg[reader_seq_pkg::CFG_CRC8];
              nxt_q.bit_cnt = '0;
            end else begin
              nxt_q = frame_tail(nxt_q);
            end
          end else begin
            nxt_q.bit_cnt = q_ff.bit_cnt + 3'd1;
            if (q_ff.bit_cnt == 3'd6) begin
              nxt_q.accept = ~fifo_in.empty;
            end
          end
        end
      end
      reader_seq_pkg::ST_TX_CRC: begin
        nxt_q.accept = 1'b0;
        if (tick) begin
          if (q_ff.bit_cnt != 3'd7) begin
            nxt_q.bit_cnt = q_ff.bit_cnt + 3'd1;
          end else if (q_ff.crc_hi) begin
            nxt_q.shreg = ~q_ff.crc[15:8];
            nxt_q.crc_hi = 1'b0;
            nxt_q.bit_cnt = '0;
          end else begin
            nxt_q = frame_tail(nxt_q);
          end
        end
      end
      reader_seq_pkg::ST_TX_EOF: begin
        if (tick) begin
          nxt_q.state = reader_seq_pkg::ST_IDLE;
          nxt_q.cmd = reader_seq_pkg::CMD_IDLE;
          nxt_q.flags[reader_seq_pkg::STS_TX_DONE] = 1'b1;
          nxt_q.flags[reader_seq_pkg::STS_CMD_DONE] = 1'b1;
        end
      end
      reader_seq_pkg::ST_RX_WAIT: begin
        if (tick) begin
          // the receiver starts as the count reaches zero
          if (q_ff.rx_cnt <= 8'h01) begin
            nxt_q.state = reader_seq_pkg::ST_RX_RUN;
            nxt_q.rx_cnt = 8'h00;
          end else begin
            nxt_q.rx_cnt = q_ff.rx_cnt - 8'h01;
          end
        end
      end
      reader_seq_pkg::ST_RX_RUN: begin
        if (rx_in.byte_valid) begin
          nxt_q.fifo_wr.push = 1'b1;
          nxt_q.fifo_wr.wdata = rx_in.data;
        end
        if (rx_in.done) begin
          nxt_q.state = reader_seq_pkg::ST_IDLE;
          nxt_q.cmd = reader_seq_pkg::CMD_IDLE;
          nxt_q.flags[reader_seq_pkg::STS_RX_DONE] = 1'b1;
          nxt_q.flags[reader_seq_pkg::STS_CMD_DONE] = 1'b1;
        end
      end
    endcase

    // host register writes, ignored during initialisation; writing idle, transmit or receive overrides the running command
    if (q_ff.dp_write && !in_init(q_ff.state)) begin
      case (q_ff.dp_addr)
        reader_seq_pkg::OFS_COMMAND: begin
          case (hwdata[7:0])
            reader_seq_pkg::CMD_IDLE: begin
              // abort without done flag; fifo is not touched
              nxt_q.state = reader_seq_pkg::ST_IDLE;
              nxt_q.cmd = reader_seq_pkg::CMD_IDLE;
              fifo_pop = 1'b0;
            end
            reader_seq_pkg::CMD_TRANSMIT: begin
              nxt_q.state = reader_seq_pkg::ST_TX_ARMED;
              nxt_q.cmd = reader_seq_pkg::CMD_TRANSMIT;
              nxt_q.accept = 1'b0;
              fifo_pop = 1'b0;
            end
            reader_seq_pkg::CMD_RECEIVE: begin
              nxt_q.state = reader_seq_pkg::ST_RX_WAIT;
              nxt_q.cmd = reader_seq_pkg::CMD_RECEIVE;
              nxt_q.rx_cnt = q_ff.rx_delay;
              nxt_q.div_cnt = '0;
              nxt_q.accept = 1'b0;
              fifo_pop = 1'b0;
            end
            default: ;
          endcase
        end
        reader_seq_pkg::OFS_REDUNDANCY_CONFIG: nxt_q.cfg = hwdata[2:0];
        reader_seq_pkg::OFS_RX_START_DELAY: nxt_q.rx_delay = hwdata[7:0];
        default: ;
      endcase
    end

    // falling reset pin restarts initialisation from the reset phase
    if (pin_fall) begin
      nxt_q.state = reader_seq_pkg::ST_RESET_PHASE;
      nxt_q.cmd = reader_seq_pkg::CMD_POWER_ON_INIT;
      nxt_q.rst_cnt = '0;
      nxt_q.flags = '0;
      nxt_q.cfg = reader_seq_pkg::CFG_RESET;
      nxt_q.rx_delay = reader_seq_pkg::RX_DELAY_RESET;
      nxt_q.init_req = 1'b0;
      nxt_q.accept = 1'b0;
      fifo_pop = 1'b0;
    end

    // registered link outputs follow the next state
    nxt_q.tx.active = nxt_q.state inside {reader_seq_pkg::ST_TX_START,
        reader_seq_pkg::ST_TX_DATA, reader_seq_pkg::ST_TX_CRC, reader_seq_pkg::ST_TX_EOF};
    nxt_q.tx.bit_val = (nxt_q.state == reader_seq_pkg::ST_TX_DATA ||
        nxt_q.state == reader_seq_pkg::ST_TX_CRC) ? nxt_q.shreg[nxt_q.bit_cnt] : 1'b0;
    unique case (nxt_q.state)
      reader_seq_pkg::ST_TX_START: nxt_q.tx.phase = reader_seq_pkg::TXP_START;
      reader_seq_pkg::ST_TX_DATA, reader_seq_pkg::ST_TX_CRC:
        nxt_q.tx.phase = reader_seq_pkg::TXP_DATA;
      reader_seq_pkg::ST_TX_EOF: nxt_q.tx.phase = reader_seq_pkg::TXP_EOF;
      default: nxt_q.tx.phase = reader_seq_pkg::TXP_NONE;
    endcase
    nxt_q.rx.enable = nxt_q.state == reader_seq_pkg::ST_RX_RUN;
    nxt_q.rx.prep = (nxt_q.state == reader_seq_pkg::ST_RX_WAIT) &&
        (nxt_q.rx_cnt <= reader_seq_pkg::RX_PREP_TOP) && (nxt_q.rx_cnt != 8'h00);
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      q_ff <= reader_seq_pkg::SEQ_RESET;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hrdata = q_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign init_load_req = q_ff.init_req;
  assign fifo_wr = q_ff.fifo_wr;
  assign tx_out = q_ff.tx;
  assign rx_ctl = q_ff.rx;

endmodule : reader_command_sequencer

// ===== bench/reader_seq_asserts.sv
// port assertions of the reader command sequencer, bound to it.
// assumes BIT_DIV equals the one given to the design.
`timescale 1ns/1ps
module reader_seq_asserts #(
  parameter logic [15:0] BIT_DIV = 16'd128
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic init_load_req,
  input wire logic fifo_pop,
  input wire reader_seq_pkg::fifo_in_t fifo_in,
  input wire reader_seq_pkg::fifo_wr_t fifo_wr,
  input wire reader_seq_pkg::tx_out_t tx_out,
  input wire reader_seq_pkg::rx_in_t rx_in,
  input wire reader_seq_pkg::rx_ctl_t rx_ctl
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [15:0] start_cnt;
  // cycles spent so far in the start phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      start_cnt <= 16'h0;
    end else begin
      start_cnt <= (tx_out.phase == reader_seq_pkg::TXP_START) ? start_cnt + 16'h1 : 16'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not okay");
  property p_init_start; $rose(rst_b) |-> ##[2:20] init_load_req; endproperty
  a_init_start: assert property (p_init_start) else $error("no init load");
  property p_init_quiet;
    init_load_req |-> !tx_out.active && !rx_ctl.enable && !fifo_pop && !fifo_wr.push;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("activity in init");
  property p_pop_ok; fifo_pop |-> !fifo_in.empty; endproperty
  a_pop_ok: assert property (p_pop_ok) else $error("pop of empty fifo");
  property p_pop_tx; fifo_pop |=> tx_out.active; endproperty
  a_pop_tx: assert property (p_pop_tx) else $error("popped byte not sent");
  property p_start_len;
    $past(tx_out.phase) == reader_seq_pkg::TXP_START && tx_out.phase == reader_seq_pkg::TXP_DATA
      |-> start_cnt == BIT_DIV;
  endproperty
  a_start_len: assert property (p_start_len) else $error("start length wrong");
  property p_idle_line;
    !tx_out.active |-> tx_out.phase == reader_seq_pkg::TXP_NONE && !tx_out.bit_val;
  endproperty
  a_idle_line: assert property (p_idle_line) else $error("tx line not idle");
  property p_bit_data; tx_out.phase != reader_seq_pkg::TXP_DATA |-> !tx_out.bit_val; endproperty
  a_bit_data: assert property (p_bit_data) else $error("bit outside data");
  property p_rx_store;
    rx_ctl.enable && rx_in.byte_valid |=> fifo_wr.push && fifo_wr.wdata == $past(rx_in.data);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("rx byte not stored");
  property p_rx_prep; $rose(rx_ctl.enable) |-> $past(rx_ctl.prep) && !rx_ctl.prep; endproperty
  a_rx_prep: assert property (p_rx_prep) else $error("receiver not prepared");
  c_eof: cover property (tx_out.phase == reader_seq_pkg::TXP_EOF);
  c_rx_push: cover property (fifo_wr.push);
  c_pop: cover property (fifo_pop ##1 tx_out.active);
endmodule : reader_seq_asserts

bind reader_command_sequencer reader_seq_asserts #(.BIT_DIV(BIT_DIV)) u_reader_seq_asserts (
  .clock(clock), .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp),
  .init_load_req(init_load_req), .fifo_pop(fifo_pop), .fifo_in(fifo_in), .fifo_wr(fifo_wr),
  .tx_out(tx_out), .rx_in(rx_in), .rx_ctl(rx_ctl));

// ===== bench/far_side_model.sv
// far side of the sequencer: show-ahead fifo fed by host and receiver,
// and the eeprom loader. assumes one clock shared with the design.
`timescale 1ns/1ps
module far_side_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic host_push,
  input wire logic [7:0] host_data,
  input wire logic fifo_pop,
  input wire reader_seq_pkg::fifo_wr_t fifo_wr,
  input wire logic init_load_req,
  output reader_seq_pkg::fifo_in_t fifo_in,
  output logic [6:0] fill,
  output logic init_load_done,
  output reader_seq_pkg::init_data_t init_data
);
  logic [7:0] q[$];
  logic [7:0] last = 8'h00;
  logic [4:0] wait_cnt;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q.delete();
      wait_cnt <= 5'h00;
    end else begin
      if (fifo_pop && q.size() > 0) begin
        last = q.pop_front();
      end
      if (host_push) begin
        q.push_back(host_data);
      end
      if (fifo_wr.push) begin
        q.push_back(fifo_wr.wdata);
      end
      wait_cnt <= init_load_req ? wait_cnt + 5'h01 : 5'h00;
    end
    fifo_in.empty <= (q.size() == 0);
    // an empty head shows the inverse of the last byte, never a stale copy
    fifo_in.rdata <= (q.size() == 0) ? ~last : q[0];
    fill <= 7'(q.size());
  end
  assign init_load_done = init_load_req && (wait_cnt == 5'h14);
  assign init_data = '{cfg: 8'h02, rx_delay: 8'h05};
endmodule : far_side_model

// ===== bench/tb_top.sv
// self-checking bench of the reader command sequencer over ahb-lite.
// assumes far_side_model as fifo and eeprom, and a bit period of 4.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, ld_req, ld_done, pop;
  logic pin = 1'b1;
  logic host_push = 1'b0;
  logic [7:0] host_data = 8'h00;
  logic [6:0] fill;
  logic saw_eof = 1'b0;
  logic saw_prep = 1'b0;
  logic [1:0] bit_t = 2'h0;
  logic tx_bits[$];
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  reader_seq_pkg::init_data_t idata;
  reader_seq_pkg::fifo_in_t fin;
  reader_seq_pkg::fifo_wr_t fwr;
  reader_seq_pkg::tx_out_t txo;
  reader_seq_pkg::rx_in_t rxi = '0;
  reader_seq_pkg::rx_ctl_t rxc;
  // command written, command read back
  logic [7:0] rows [5][2] = '{'{8'h16, 8'h16}, '{8'h00, 8'h00}, '{8'h55, 8'h00},
    '{8'h1a, 8'h1a}, '{8'h00, 8'h00}};
  reader_command_sequencer #(.BIT_DIV(16'd4)) u_reader_command_sequencer (
    .clock(clock), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .haddr(haddr), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reset_powerdown_pin(pin),
    .init_load_req(ld_req), .init_load_done(ld_done), .init_data(idata), .fifo_in(fin),
    .fifo_pop(pop), .fifo_wr(fwr), .tx_out(txo), .rx_in(rxi), .rx_ctl(rxc));
  far_side_model u_far_side_model (.clock(clock), .rst_b(rst_b), .host_push(host_push),
    .host_data(host_data), .fifo_pop(pop), .fifo_wr(fwr), .init_load_req(ld_req),
    .fifo_in(fin), .fill(fill), .init_load_done(ld_done), .init_data(idata));
  initial begin
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // one bit taken per 4-cycle bit period of the data phase
  always @(posedge clock) begin
    bit_t <= (txo.phase == reader_seq_pkg::TXP_DATA) ? bit_t + 2'h1 : 2'h0;
    if (txo.phase == reader_seq_pkg::TXP_DATA && bit_t == 2'h0) tx_bits.push_back(txo.bit_val);
    if (txo.phase == reader_seq_pkg::TXP_EOF) saw_eof = 1'b1;
    if (rxc.prep) saw_prep = 1'b1;
  end
  task automatic end_sim();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic push(input logic [7:0] b);
    @(posedge clock);
    host_push <= 1'b1;
    host_data <= b;
    @(posedge clock);
    host_push <= 1'b0;
  endtask : push
  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      ahb(1'b0, 8'h00, 32'h0);
      if (rd === 32'h0) return;
    end
    `CHK(rd, 32'h0)
  endtask : wait_idle
  task automatic start_tx(input logic [31:0] cfg);
    ahb(1'b1, 8'h04, 32'h7);
    ahb(1'b1, 8'h20, cfg);
    tx_bits.delete();
    saw_eof = 1'b0;
    ahb(1'b1, 8'h00, 32'h1a);
  endtask : start_tx
  task automatic chk_tx(input logic [7:0] b[$], input logic crc_on, input logic eof_exp);
    logic [15:0] c;
    logic [7:0] all[$];
    logic [63:0] exp_v, got_v;
    c = reader_seq_pkg::CRC16_PRESET;
    all = b;
    foreach (b[i]) for (int k = 0; k < 8; k++)
      c = (c[0] ^ b[i][k]) ? (c >> 1) ^ reader_seq_pkg::CRC16_POLY : c >> 1;
    if (crc_on) all = {all, ~c[7:0], ~c[15:8]};
    exp_v = '0;
    got_v = '0;
    foreach (all[i]) exp_v[i*8 +: 8] = all[i];
    foreach (tx_bits[i]) got_v[i] = tx_bits[i];
    `CHK(tx_bits.size(), all.size() * 8)
    `CHK(got_v, exp_v)
    `CHK(saw_eof, eof_exp)
  endtask : chk_tx
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    ahb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h3f)
    ahb(1'b0, 8'h24, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h3f)
    wait_idle();
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(rd[0], 1'b1)
    ahb(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h2)
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b1, 8'h04, 32'h7);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b1, 8'h00, {24'h0, rows[i][0]});
      ahb(1'b0, 8'h00, 32'h0);
      `CHK(rd[7:0], rows[i][1])
    end
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(rd[2:0], 3'h0)
    push(8'h11);
    push(8'h22);
    push(8'h33);
    start_tx(32'h1);
    ahb(1'b1, 8'h00, 32'h0);
    @(posedge clock);
    #1;
    `CHK({txo.active, fill}, {1'b0, 7'd2})
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(rd[2:0], 3'h0)
    start_tx(32'h1);
    wait_idle();
    chk_tx('{8'h22, 8'h33}, 1'b1, 1'b1);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(rd[1:0], 2'h3)
    start_tx(32'h4);
    repeat (10) @(posedge clock);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK({rd[4], txo.active}, 2'b10)
    push(8'h44);
    repeat (6) @(posedge clock);
    push(8'h55);
    wait_idle();
    chk_tx('{8'h44, 8'h55}, 1'b0, 1'b0);
    ahb(1'b1, 8'h24, 32'h3);
    ahb(1'b1, 8'h00, 32'h16);
    for (int i = 0; i < 200 && rxc.enable !== 1'b1; i++) @(posedge clock);
    `CHK({saw_prep, rxc.enable}, 2'b11)
    rxi <= '{byte_valid: 1'b1, data: 8'ha5, done: 1'b0};
    @(posedge clock);
    rxi <= '{byte_valid: 1'b0, data: 8'h5a, done: 1'b1};
    @(posedge clock);
    rxi <= '0;
    wait_idle();
    `CHK({fill, fin.rdata}, {7'd1, 8'ha5})
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(rd[2], 1'b1)
    pin <= 1'b0;
    repeat (3) @(posedge clock);
    pin <= 1'b1;
    repeat (4) @(posedge clock);
    ahb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h3f)
    wait_idle();
    end_sim();
  end
endmodule : tb_top
